// [bench/eph_host_assertions.sv]
/*
  port checker for the eeprom host controller.
  assumes one clock and a synchronous active-high reset.
*/
`timescale 1ns/1ps
`include "eph_map.vh"
module eph_host_chk #(
  parameter PUR_CYC = 60
) (
  input wire                   clk,
  input wire                   reset,
  input wire                   req_valid,
  input wire                   req_ready,
  input wire                   req_write,
  input wire                   req_last,
  input wire                   rsp_valid,
  input wire                   write_done,
  input wire                   write_timeout,
  input wire [`EPH_ADDR_W-1:0] address_pins,
  input wire [7:0]             data_out,
  input wire                   data_oe,
  input wire                   out_en_n,
  input wire                   wr_en_n,
  input wire                   chip_sel_n
);
  localparam int SP_MIN = 38;
  reg [15:0] up_q;
  reg [15:0] gap_q;
  // cycles since reset release and since the last write strobe fall
  always @(posedge clk) begin
    up_q  <= reset ? 16'h0 : (&up_q ? up_q : up_q + 16'h1);
    gap_q <= reset ? 16'hffff :
             ($fell(wr_en_n) ? 16'h0 : (&gap_q ? gap_q : gap_q + 16'h1));
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  sequence take_rd; req_valid && req_ready && !req_write; endsequence
  sequence take_wr; req_valid && req_ready && req_write; endsequence
  sequence take_last;
    req_valid && req_ready && req_write && req_last;
  endsequence
  a_no_both_strobes: assert property (out_en_n || wr_en_n)
    else $error("read and write strobes low together");
  a_read_no_drive: assert property (!out_en_n |-> !data_oe)
    else $error("host drives data during a read");
  a_write_drives: assert property (!wr_en_n |-> data_oe && !chip_sel_n)
    else $error("write strobe without select or data");
  a_wr_width: assert property ($fell(wr_en_n) |->
    (!wr_en_n)[*8] ##1 (!wr_en_n)[*5])
    else $error("write strobe too short");
  a_wr_stable: assert property (!wr_en_n && $past(!wr_en_n) |->
    $stable(address_pins) && $stable(data_out))
    else $error("address or data moved in write strobe");
  a_wr_start: assert property (take_wr |=> !chip_sel_n && !wr_en_n)
    else $error("write strobe late");
  a_rd_answer: assert property (take_rd |-> ##[20:40] rsp_valid)
    else $error("read answer missing");
  a_rd_width: assert property ($fell(out_en_n) |-> (!out_en_n)[*8])
    else $error("read strobe too short");
  a_done_bound: assert property (take_last |->
    ##[1:1000] (write_done || write_timeout))
    else $error("write end not reported");
  a_load_space: assert property ($fell(wr_en_n) |-> gap_q >= SP_MIN - 1)
    else $error("byte loads too close");
  a_pur_gate: assert property (req_ready |-> up_q + 16'h2 >= PUR_CYC)
    else $error("request taken too soon after reset");
endmodule
bind eph_host eph_host_chk #(.PUR_CYC(PUR_CYC)) u_chk (.*);

// [bench/eph_host_tb_top.sv]
/*
  testbench: page write, read back, slow programming with timeout.
  assumes the device model of eph_mem_model on the memory pins.
*/
`timescale 1ns/1ps
`include "eph_map.vh"
module eph_host_tb_top;
  reg         clk = 0, reset = 1, req_valid = 0, req_write = 0, req_last = 0;
  reg  [12:0] req_addr = 0, base;
  reg  [7:0]  req_wdata = 0, wd;
  wire        req_ready, rsp_valid, write_done, write_timeout, data_oe;
  wire        chip_sel_n, out_en_n, wr_en_n;
  wire [12:0] address_pins;
  wire [7:0]  rsp_rdata, data_out, mem_dq, pin;
  integer     num_errors = 0, comparisons = 0, seed = 32'h1df9, i;
  integer     ref_mem [0:8191];
  always #2 clk = ~clk;
  assign pin = data_oe ? data_out : mem_dq;
  eph_host #(.PUW_CYC(60), .PUR_CYC(60), .PROG_CYC(400), .SPMAX_CYC(200))
  DUT (.clk(clk), .reset(reset), .req_valid(req_valid),
    .req_ready(req_ready), .req_write(req_write), .req_last(req_last),
    .req_addr(req_addr), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_rdata(rsp_rdata), .write_done(write_done),
    .write_timeout(write_timeout), .address_pins(address_pins),
    .data_out(data_out), .data_oe(data_oe), .data_in(pin),
    .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_en_n(wr_en_n));
  eph_mem_model u_mem (.clk(clk), .addr(address_pins), .din(pin),
    .cs_n(chip_sel_n), .oe_n(out_en_n), .we_n(wr_en_n), .dq(mem_dq));
  task check(input string name, input logic [31:0] seen, exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        num_errors = num_errors + 1;
        $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // hold the request from a falling edge until a rising edge takes it
  task issue(input w, input l, input [12:0] a, input [7:0] d);
    integer k;
    begin
      @(negedge clk);
      {req_valid, req_write, req_last, req_addr, req_wdata} = {1'b1, w, l, a, d};
      #1;
      for (k = 0; k < 4000 && req_ready !== 1'b1; k = k + 1) @(negedge clk);
      if (k == 4000)
        num_errors = num_errors + 1;
      @(negedge clk);
      req_valid = 0;
    end
  endtask
  task wait_ev(input integer lim);
    integer k;
    begin
      for (k = 0; k < lim && (rsp_valid | write_done | write_timeout) !== 1'b1;
           k = k + 1) begin
        @(posedge clk);
        #1;
      end
    end
  endtask
  task rd_chk(input [12:0] a);
    begin
      issue(0, 0, a, 8'h00);
      wait_ev(100);
      check("rsp_valid", rsp_valid, 1);
      check("rsp_rdata", rsp_rdata, ref_mem[a]);
    end
  endtask
  task end_sim;
    begin
      $display("comparisons %0d mismatches %0d", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #100000;
    num_errors = num_errors + 1;
    end_sim;
  end
  initial begin
    for (i = 0; i < 8192; i = i + 1) ref_mem[i] = 0;
    repeat (3) @(posedge clk);
    @(negedge clk) reset = 0;
    check("idle pins", {chip_sel_n, out_en_n, wr_en_n, data_oe}, 4'he);
    check("ready early", req_ready, 0);
    $display("test reset done");
    base = $random(seed);
    base[5:0] = 6'h3c;
    for (i = 0; i < 4; i = i + 1) begin
      wd = $random(seed);
      ref_mem[base + i] = wd;
      issue(1, i == 3, base + i, wd);
    end
    wait_ev(2000);
    check("write_done", {write_done, write_timeout}, 2'h2);
    for (i = 0; i < 4; i = i + 1) rd_chk(base + i);
    $display("test page write done");
    u_mem.prog_cyc = 3000;
    wd = $random(seed);
    ref_mem[13'h1fff] = wd;
    issue(1, 1, 13'h1fff, wd);
    wait_ev(2000);
    check("write_timeout", {write_done, write_timeout}, 2'h1);
    repeat (3000) @(posedge clk);
    rd_chk(13'h1fff);
    $display("test slow programming done");
    end_sim;
  end
endmodule

// [bench/eph_mem_model.sv]
/*
  behavioural byte-wide eeprom with self-timed programming and toggle bit.
  assumes it is sampled on the host clock; prog_cyc is set by the bench.
*/
`timescale 1ns/1ps
module eph_mem_model (
  input  wire        clk,
  input  wire [12:0] addr,
  input  wire [7:0]  din,
  input  wire        cs_n,
  input  wire        oe_n,
  input  wire        we_n,
  output reg  [7:0]  dq
);
  reg [7:0] mem [0:8191];
  integer   prog_cyc;
  integer   left;
  integer   j;
  reg       tog, rd, wr, rd_q, wr_q;
  initial begin
    for (j = 0; j < 8192; j = j + 1) mem[j] = 8'h00;
    prog_cyc = 100;
    left = 0;
    {tog, rd_q, wr_q} = 3'h0;
    dq = 8'h5a;
  end
  // decode, latch at end of strobe, then self-time the programming
  always @(posedge clk) begin
    rd = !cs_n && !oe_n && we_n;
    wr = !cs_n && !we_n && oe_n;
    if (wr_q && !wr) begin
      mem[addr] = din;
      left = prog_cyc;
    end else if (left > 0)
      left = left - 1;
    if (rd && !rd_q && left > 0)
      tog = !tog;
    if (rd)
      dq <= (left > 0) ? {mem[addr][7], tog, mem[addr][5:0]} : mem[addr];
    else
      dq <= ~dq; // floating pins show a moving pattern
    rd_q = rd;
    wr_q = wr;
  end
endmodule

// [core/eph_host.v]
/*
  host controller driving a parallel byte-wide eeprom: reads, byte
  loads grouped into pages, and end-of-write polling by read cycles.
  assumes the memory pins are wired straight to the device and that
  data pins are resolved from data_oe outside this module.
*/
`timescale 1ns/1ps
`include "eph_map.vh"
module eph_host #(
  parameter PUW_CYC  = `EPH_CYC_PUW,
  parameter PUR_CYC  = `EPH_CYC_PUR,
  parameter PROG_CYC = `EPH_CYC_PROG,
  parameter SPMAX_CYC = `EPH_CYC_SPMAX
) (
  input  wire                  clk,
  input  wire                  reset,
  input  wire                  req_valid,
  output wire                  req_ready,
  input  wire                  req_write,
  input  wire                  req_last,
  input  wire [`EPH_ADDR_W-1:0] req_addr,
  input  wire [7:0]            req_wdata,
  output reg                   rsp_valid,
  output reg  [7:0]            rsp_rdata,
  output reg                   write_done,
  output reg                   write_timeout,
  output reg  [`EPH_ADDR_W-1:0] address_pins,
  output reg  [7:0]            data_out,
  output reg                   data_oe,
  input  wire [7:0]            data_in,
  output reg                   chip_sel_n,
  output reg                   out_en_n,
  output reg                   wr_en_n
);
  localparam [3:0] S_PWR   = 4'd0;
  localparam [3:0] S_IDLE  = 4'd1;
  localparam [3:0] S_RD    = 4'd2;
  localparam [3:0] S_RDEND = 4'd3;
  localparam [3:0] S_WR    = 4'd4;
  localparam [3:0] S_WREND = 4'd5;
  localparam [3:0] S_PAGE  = 4'd6;
  localparam [3:0] S_POLL  = 4'd7;
  localparam [3:0] S_PEND  = 4'd8;
  localparam [3:0] S_PGAP  = 4'd9;

  localparam [`EPH_TMR_W-1:0] C_READ  = `EPH_CYC_READ;
  localparam [`EPH_TMR_W-1:0] C_PULSE = `EPH_CYC_PULSE;
  localparam [`EPH_TMR_W-1:0] C_HOLD  = `EPH_CYC_HOLD;
  localparam [`EPH_TMR_W-1:0] C_HZ    = `EPH_CYC_HZ;
  localparam [`EPH_TMR_W-1:0] C_SPMIN = `EPH_CYC_SPMIN;
  localparam [`EPH_TMR_W-1:0] C_PUW   = PUW_CYC;
  localparam [`EPH_TMR_W-1:0] C_PUR   = PUR_CYC;
  localparam [`EPH_TMR_W-1:0] C_PROG  = PROG_CYC;
  localparam [`EPH_TMR_W-1:0] C_SPMAX = SPMAX_CYC;

  reg  [3:0]             state_q;
  reg  [`EPH_TMR_W-1:0]  tmr_val;
  reg                    tmr_load;
  wire                   tmr_done;
  reg  [`EPH_TMR_W-1:0]  prog_q;      // program deadline counter
  reg  [`EPH_TMR_W-1:0]  spc_q;       // time since last byte load
  reg  [`EPH_TMR_W-1:0]  pur_q;       // power-up read gate
  reg  [`EPH_TMR_W-1:0]  puw_q;       // power-up write gate
  reg                    poll_same_q; // two polls saw bit 6 unchanged
  reg  [7:0]             din_s1_q;
  reg  [7:0]             din_s2_q;
  reg  [7:0]             poll_prev_q;
  reg                    poll_first_q;
  reg                    last_q;

  // pin inputs pass two flops before use
  always @(posedge clk) begin
    din_s1_q <= data_in;
    din_s2_q <= din_s1_q;
  end

  eph_timer u_tmr (
    .clk   (clk),
    .reset (reset),
    .load  (tmr_load),
    .value (tmr_val),
    .done  (tmr_done)
  );

  wire read_ok    = (pur_q == {`EPH_TMR_W{1'b0}});
  wire write_ok   = (puw_q == {`EPH_TMR_W{1'b0}});
  wire space_ok   = (spc_q >= C_SPMIN);
  wire page_close = (spc_q == C_SPMAX) & ~last_q;
  // no request is offered in the cycle that closes an open page
  assign req_ready = (state_q == S_IDLE) & tmr_done & read_ok &
                     ~page_close &
                     (~req_write | (space_ok & write_ok));

  // side counters: power-up read and write gates, byte spacing, program deadline
  always @(posedge clk) begin
    if (reset) begin
      pur_q  <= C_PUR;
      puw_q  <= C_PUW;
      spc_q  <= {`EPH_TMR_W{1'b1}};
      prog_q <= {`EPH_TMR_W{1'b0}};
    end else begin
      if (read_ok == 1'b0)
        pur_q <= pur_q - {{(`EPH_TMR_W-1){1'b0}}, 1'b1};
      if (write_ok == 1'b0)
        puw_q <= puw_q - {{(`EPH_TMR_W-1){1'b0}}, 1'b1};
      if (state_q == S_WREND)
        spc_q <= {`EPH_TMR_W{1'b0}};
      else if (spc_q != {`EPH_TMR_W{1'b1}})
        spc_q <= spc_q + {{(`EPH_TMR_W-1){1'b0}}, 1'b1};
      if (state_q == S_PAGE)
        prog_q <= C_PROG;
      else if (prog_q != {`EPH_TMR_W{1'b0}})
        prog_q <= prog_q - {{(`EPH_TMR_W-1){1'b0}}, 1'b1};
    end
  end

  // timer load requests per state entry
  always @* begin
    tmr_load = 1'b0;
    tmr_val  = C_PULSE;
    case (state_q)
      S_IDLE: begin
        if (req_valid & req_ready) begin
          tmr_load = 1'b1;
          tmr_val  = req_write ? C_PULSE : C_READ;
        end
      end
      S_RD, S_POLL: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = C_HZ;
        end
      end
      S_WR: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = C_HOLD;
        end
      end
      S_PAGE, S_PGAP: begin
        if (tmr_done) begin
          tmr_load = 1'b1;
          tmr_val  = C_READ;
        end
      end
      default: begin
        tmr_load = 1'b0;
      end
    endcase
  end

  // main sequencer driving the control pins
  always @(posedge clk) begin
    if (reset) begin
      state_q       <= S_PWR;
      chip_sel_n    <= 1'b1;
      out_en_n      <= 1'b1;
      wr_en_n       <= 1'b1;
      data_oe       <= 1'b0;
      data_out      <= 8'h00;
      address_pins  <= {`EPH_ADDR_W{1'b0}};
      rsp_valid     <= 1'b0;
      rsp_rdata     <= 8'h00;
      write_done    <= 1'b0;
      write_timeout <= 1'b0;
      poll_prev_q   <= 8'h00;
      poll_first_q  <= 1'b0;
      poll_same_q   <= 1'b0;
      last_q        <= 1'b0;
    end else begin
      rsp_valid     <= 1'b0;
      write_done    <= 1'b0;
      write_timeout <= 1'b0;
      case (state_q)
        S_PWR: begin
          state_q <= S_IDLE;
        end
        S_IDLE: begin
          // page closes if spacing max passes without a load while the sequencer is in S_IDLE
          if (page_close)
            state_q <= S_PAGE;
          else if (req_valid & req_ready) begin
            address_pins <= req_addr;
            chip_sel_n   <= 1'b0;
            if (req_write) begin
              wr_en_n  <= 1'b0;
              data_out <= req_wdata;
              data_oe  <= 1'b1;
              last_q   <= req_last;
              state_q  <= S_WR;
            end else begin
              out_en_n <= 1'b0;
              state_q  <= S_RD;
            end
          end
        end
        S_RD: begin
          if (tmr_done) begin
            rsp_rdata <= din_s2_q;
            chip_sel_n <= 1'b1;
            out_en_n  <= 1'b1;
            rsp_valid <= 1'b1;
            state_q   <= S_RDEND;
          end
        end
        S_RDEND: begin
          if (tmr_done)
            state_q <= S_IDLE;
        end
        S_WR: begin
          // single write timing per byte load
          if (tmr_done) begin
            wr_en_n    <= 1'b1;
            chip_sel_n <= 1'b1;
            state_q    <= S_WREND;
          end
        end
        S_WREND: begin
          if (tmr_done) begin
            data_oe <= 1'b0;
            state_q <= last_q ? S_PAGE : S_IDLE;
          end
        end
        S_PAGE: begin
          poll_first_q <= 1'b1;
          last_q       <= 1'b1;
          if (tmr_done) begin
            chip_sel_n <= 1'b0;
            out_en_n   <= 1'b0;
            state_q    <= S_POLL;
          end
        end
        S_POLL: begin
          // toggle-bit poll as an ordinary read cycle
          if (tmr_done) begin
            // compare while the read data still stands on the pins
            chip_sel_n   <= 1'b1;
            out_en_n     <= 1'b1;
            poll_same_q  <= ~poll_first_q &
                            (din_s2_q[6] == poll_prev_q[6]);
            poll_prev_q  <= din_s2_q;
            poll_first_q <= 1'b0;
            state_q      <= S_PEND;
          end
        end
        S_PEND: begin
          if (tmr_done) begin
            if (poll_same_q & prog_q != C_PROG) begin
              write_done <= 1'b1;
              state_q    <= S_IDLE;
            end else if (prog_q == {`EPH_TMR_W{1'b0}}) begin
              write_timeout <= 1'b1;
              state_q       <= S_IDLE;
            end else
              state_q <= S_PGAP;
          end
        end
        S_PGAP: begin
          // output enable only falls with select low, never bare
          if (tmr_done) begin
            chip_sel_n <= 1'b0;
            out_en_n   <= 1'b0;
            state_q    <= S_POLL;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end
endmodule

// [core/eph_map.vh]
/*
  constants for the host-side controller of a parallel byte-wide
  electrically erasable memory; assumes a 250 MHz controller clock.
*/
// Functional notes
// - host waits 5 ms unless polling completion
// - page byte loads spaced 0.15 to 100 us; a read running when the spacing max passes leaves the page open past it
// - each byte load follows single write timing
// - output enable pulse with select high tolerated
// - output enable low with select low polls
// - polling uses ordinary read cycles and timing
`ifndef EPH_MAP_VH
`define EPH_MAP_VH
`define EPH_CLK_MHZ           250
`define EPH_ADDR_W            13
`define EPH_PAGE_BYTES        64
// times in ns, us or ms as named in each macro
`define EPH_T_READ_NS         120
`define EPH_T_PULSE_NS        50
`define EPH_T_HOLD_NS         50
`define EPH_T_HZ_NS           30
`define EPH_T_SPACE_MIN_NS    150
`define EPH_T_SPACE_MAX_US    100
`define EPH_T_PROG_MAX_MS     5
`define EPH_T_PUR_US          100
`define EPH_T_PUW_MS          5
// cycle counts: minimums rounded up, maximums rounded down
`define EPH_CYC_READ   ((`EPH_T_READ_NS*`EPH_CLK_MHZ+999)/1000)
`define EPH_CYC_PULSE  ((`EPH_T_PULSE_NS*`EPH_CLK_MHZ+999)/1000)
`define EPH_CYC_HOLD   ((`EPH_T_HOLD_NS*`EPH_CLK_MHZ+999)/1000)
`define EPH_CYC_HZ     ((`EPH_T_HZ_NS*`EPH_CLK_MHZ+999)/1000)
`define EPH_CYC_SPMIN  ((`EPH_T_SPACE_MIN_NS*`EPH_CLK_MHZ+999)/1000)
`define EPH_CYC_SPMAX  (`EPH_T_SPACE_MAX_US*`EPH_CLK_MHZ)
`define EPH_CYC_PROG   (`EPH_T_PROG_MAX_MS*1000*`EPH_CLK_MHZ)
`define EPH_CYC_PUR    (`EPH_T_PUR_US*`EPH_CLK_MHZ)
`define EPH_CYC_PUW    (`EPH_T_PUW_MS*1000*`EPH_CLK_MHZ)
`define EPH_TMR_W      24
`endif

// [core/eph_timer.v]
/*
  down-counting delay timer with load and expiry flag.
  assumes a single synchronous clock domain.
*/
`timescale 1ns/1ps
`include "eph_map.vh"
module eph_timer (
  input  wire                  clk,
  input  wire                  reset,
  input  wire                  load,
  input  wire [`EPH_TMR_W-1:0] value,
  output wire                  done
);
  reg [`EPH_TMR_W-1:0] cnt_q;

  // load wins; otherwise count down to zero and stop
  always @(posedge clk) begin
    if (reset) begin
      cnt_q <= {`EPH_TMR_W{1'b0}};
    end else if (load) begin
      cnt_q <= value;
    end else if (cnt_q != {`EPH_TMR_W{1'b0}}) begin
      cnt_q <= cnt_q - {{(`EPH_TMR_W-1){1'b0}}, 1'b1};
    end
  end

  // done must not look at load: callers derive load from done
  assign done = (cnt_q == {`EPH_TMR_W{1'b0}});
endmodule
